// >>> srd_config.sv
// Summary of operation
// (RL1) Bit 13 picks the control origin for even self-selected channels, 0 reluctance, 1 config bit, reset 1.
// (RL2) Bit 12 makes the same choice for odd channels and resets to 0.
// (RL3) Bits 11:8 enable a 1 us filter per SENT channel, resetting to the SENT enable reset value.
// (RL4) Bits 7:4 pick the analog output source: high-Z, channels 1-12, bandgap, ADC reference, reluctance input.
// (RL5) Bits 3:0 enable SENT on channels 1 to 4 and reset to zero.
// (RL6) Dewetting register bits 12:9 enable binary lambda mode on channels 9 to 12, reset zero.
// (RL7) Bits 7:5 set the dewetting time from 2 ms to 2048 ms, reset 000.
// (RL8) Bits 4:0 set the variable voltage at 800 mV plus 50 mV per code step.
// (RL9) Codes 10110 and above saturate at 1900 mV.
// (RL10) Each dewetting register write resets the current-source setup of channels 9 to 12.
// (RL11) That default is a 250 uA pull-up to 5 V with lambda mode on, else high impedance.
// (RL12) A channel selecting itself as control takes reluctance path or config bit per odd/even bit.
// (RL13) In lambda mode pull code 111 means pull-up to variable voltage if control is 1, else to 5 V.
// (RL14) Reserved bits read as zero and ignore writes.
module srd_config (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire srd_pkg::srd_wr_t wrReq,
  input  wire logic [7:0]       rdAddr,
  input  wire logic [3:0]       chanNum,
  input  wire logic [3:0]       ctrlInputSel,
  input  wire logic             reluctancePath,
  input  wire logic             ctrlCfgBit,
  input  wire logic [2:0]       pullSel,
  output logic      [15:0]      rdData,
  output srd_pkg::srd_cfg_t     cfg,
  output logic      [10:0]      varVoltageMv,
  output logic                  csDefaultLoad,
  output srd_pkg::srd_cs_t [3:0] csDefault,
  output logic                  selfCtrlSignal,
  output logic                  lambdaPullVvar
);
  import srd_pkg::*;

  typedef struct packed {
    srd_cfg_t         cfg;
    logic [15:0]      rdData;
    logic [10:0]      mv;
    logic             csLoad;
    srd_cs_t [3:0]    csDef;
    logic             selfCtrl;
    logic             pullVvar;
  } srd_state_t;

  srd_state_t state;
  srd_state_t next_state;
  logic [10:0] decMv;
  logic [15:0] routeWord;
  logic [15:0] dewetWord;
  logic        ctrlOrigin;

  srd_variable_voltage_source_decode uDec (
    .code    (next_state.cfg.vvarCode),
    .levelMv (decMv)
  );

  always_comb begin
    routeWord = '0;
    dewetWord = '0;
    // Reserved positions stay zero [RL14]
    routeWord[EVEN_BIT] = state.cfg.evenSel;
    routeWord[ODD_BIT] = state.cfg.oddSel;
    routeWord[FILT_LSB +: 4] = state.cfg.filterEn;
    routeWord[AOUT_LSB +: 4] = state.cfg.aoutSel;
    routeWord[SENT_LSB +: 4] = state.cfg.sentEn;
    dewetWord[LAMBDA_LSB +: 4] = state.cfg.lambdaEn;
    dewetWord[DWT_LSB +: 3] = state.cfg.dwtSel;
    dewetWord[VARIABLE_VOLTAGE_SOURCE_LSB +: 5] = state.cfg.vvarCode;
    // Control origin for self-selected channels; even/odd by LSB [RL1] [RL2] [RL12]
    ctrlOrigin = chanNum[0] ? state.cfg.oddSel : state.cfg.evenSel;
  end

  always_comb begin
    next_state = state;
    next_state.csLoad = 1'b0;
    if (wrReq.wrEn && wrReq.addr == ROUTE_ADDR) begin
      next_state.cfg.evenSel = wrReq.wdata[EVEN_BIT];             // [RL1]
      next_state.cfg.oddSel = wrReq.wdata[ODD_BIT];               // [RL2]
      next_state.cfg.filterEn = wrReq.wdata[FILT_LSB +: 4];       // [RL3]
      next_state.cfg.aoutSel = wrReq.wdata[AOUT_LSB +: 4];        // [RL4]
      next_state.cfg.sentEn = wrReq.wdata[SENT_LSB +: 4];         // [RL5]
    end
    if (wrReq.wrEn && wrReq.addr == DEWET_ADDR) begin
      next_state.cfg.lambdaEn = wrReq.wdata[LAMBDA_LSB +: 4];     // [RL6]
      next_state.cfg.dwtSel = wrReq.wdata[DWT_LSB +: 3];          // [RL7]
      next_state.cfg.vvarCode = wrReq.wdata[VARIABLE_VOLTAGE_SOURCE_LSB +: 5];       // [RL8]
      // Any write reverts channels 9-12, using the newly written lambda bits [RL10]
      next_state.csLoad = 1'b1;
      for (int i = 0; i < LAMBDA_LANES; i++) begin
        next_state.csDef[i] = wrReq.wdata[LAMBDA_LSB + i] ? SRD_CS_PU250_5V
                                                          : SRD_CS_HIZ; // [RL11]
      end
    end
    next_state.mv = decMv;                                        // [RL9]
    case (rdAddr)
      ROUTE_ADDR: next_state.rdData = routeWord;
      DEWET_ADDR: next_state.rdData = dewetWord;
      default:    next_state.rdData = 16'h0000;
    endcase
    next_state.selfCtrl = (ctrlInputSel == chanNum) && (chanNum != 4'h0)
                          ? (ctrlOrigin ? ctrlCfgBit : reluctancePath) : 1'b0; // [RL12]
    // Lambda-mode pull target; chanNum 9..12 maps to lane 0..3 [RL13]
    next_state.pullVvar = 1'b0;
    if (chanNum >= 4'h9 && chanNum <= AOUT_CH_MAX && pullSel == PULL_LAMBDA) begin
      next_state.pullVvar = state.cfg.lambdaEn[2'(chanNum - 4'h9)] && next_state.selfCtrl;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state.cfg.evenSel <= EVEN_RST;
      state.cfg.oddSel <= ODD_RST;
      state.cfg.filterEn <= SENT_RST;   // Tracks SENT enable reset value
      state.cfg.aoutSel <= AOUT_RST;
      state.cfg.sentEn <= SENT_RST;
      state.cfg.lambdaEn <= LAMBDA_RST;
      state.cfg.dwtSel <= DWT_RST;
      state.cfg.vvarCode <= VARIABLE_VOLTAGE_SOURCE_RST;
      state.rdData <= 16'h0000;
      state.mv <= 11'(VARIABLE_VOLTAGE_SOURCE_BASE_MV);
      state.csLoad <= 1'b0;
      state.csDef <= {4{SRD_CS_DEFAULT}};
      state.selfCtrl <= 1'b0;
      state.pullVvar <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign rdData = state.rdData;
  assign cfg = state.cfg;
  assign varVoltageMv = state.mv;
  assign csDefaultLoad = state.csLoad;
  assign csDefault = state.csDef;
  assign selfCtrlSignal = state.selfCtrl;
  assign lambdaPullVvar = state.pullVvar;

  sequence s_dewet_write;
    wrReq.wrEn && wrReq.addr == DEWET_ADDR;
  endsequence

  a_dewet_reload: assert property (@(posedge clk) disable iff (!arst_n) // [RL10]
    s_dewet_write |=> csDefaultLoad)
    else $error("dewet write did not reload current sources");
  a_load_only_write: assert property (@(posedge clk) disable iff (!arst_n) // [RL10]
    csDefaultLoad |-> $past(wrReq.wrEn) && $past(wrReq.addr) == DEWET_ADDR)
    else $error("spurious current source reload");
  a_default_kind: assert property (@(posedge clk) disable iff (!arst_n) // [RL11]
    csDefaultLoad |-> (csDefault[0] == SRD_CS_PU250_5V) == cfg.lambdaEn[0])
    else $error("wrong current source default");
  a_variable_voltage_source_saturate: assert property (@(posedge clk) disable iff (!arst_n) // [RL9]
    cfg.vvarCode >= VARIABLE_VOLTAGE_SOURCE_SAT_CODE |=> varVoltageMv == VARIABLE_VOLTAGE_SOURCE_MAX_MV || $changed(cfg.vvarCode))
    else $error("variable voltage not saturated");
  a_variable_voltage_source_base: assert property (@(posedge clk) disable iff (!arst_n) // [RL8]
    $rose(cfg.vvarCode == 5'h00) |-> varVoltageMv == 11'd800)
    else $error("variable voltage base wrong");
  a_route_store: assert property (@(posedge clk) disable iff (!arst_n) // [RL4]
    wrReq.wrEn && wrReq.addr == ROUTE_ADDR |=> cfg.aoutSel == $past(wrReq.wdata[7:4]))
    else $error("analog source not stored");
  a_sent_store: assert property (@(posedge clk) disable iff (!arst_n) // [RL5]
    wrReq.wrEn && wrReq.addr == ROUTE_ADDR |=> cfg.sentEn == $past(wrReq.wdata[3:0]))
    else $error("sent enables not stored");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n) // [RL14]
    rdData[15:14] == 2'b00)
    else $error("reserved bits read nonzero");
  a_lambda_store: assert property (@(posedge clk) disable iff (!arst_n) // [RL6]
    s_dewet_write |=> cfg.lambdaEn == $past(wrReq.wdata[12:9]))
    else $error("lambda enables not stored");

  sequence s_route_write;
    wrReq.wrEn && wrReq.addr == ROUTE_ADDR;
  endsequence

  sequence s_self_select;
    ctrlInputSel == chanNum && chanNum != 4'h0;
  endsequence

  a_even_store: assert property (@(posedge clk) disable iff (!arst_n) // [RL1]
    s_route_write |=> cfg.evenSel == $past(wrReq.wdata[13]))
    else $error("even origin bit not stored");
  a_odd_store: assert property (@(posedge clk) disable iff (!arst_n) // [RL2]
    s_route_write |=> cfg.oddSel == $past(wrReq.wdata[12]))
    else $error("odd origin bit not stored");
  a_filter_store: assert property (@(posedge clk) disable iff (!arst_n) // [RL3]
    s_route_write |=> cfg.filterEn == $past(wrReq.wdata[11:8]))
    else $error("filter enables not stored");
  a_dwt_store: assert property (@(posedge clk) disable iff (!arst_n) // [RL7]
    s_dewet_write |=> cfg.dwtSel == $past(wrReq.wdata[7:5]))
    else $error("dewet time not stored");
  a_variable_voltage_source_store: assert property (@(posedge clk) disable iff (!arst_n) // [RL8]
    s_dewet_write |=> cfg.vvarCode == $past(wrReq.wdata[4:0]))
    else $error("voltage code not stored");
  a_dewet_reserved: assert property (@(posedge clk) disable iff (!arst_n) // [RL14]
    $past(rdAddr) == DEWET_ADDR |-> rdData[13] == 1'b0 && rdData[8] == 1'b0)
    else $error("dewet reserved bits read nonzero");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n) // [RL14]
    $past(rdAddr) != ROUTE_ADDR && $past(rdAddr) != DEWET_ADDR |-> rdData == 16'h0000)
    else $error("unmapped address read nonzero");
  a_odd_cfgbit: assert property (@(posedge clk) disable iff (!arst_n) // [RL12]
    s_self_select ##0 (chanNum[0] && cfg.oddSel) |=> selfCtrlSignal == $past(ctrlCfgBit))
    else $error("odd channel ignored config bit");
  a_even_path: assert property (@(posedge clk) disable iff (!arst_n) // [RL1]
    s_self_select ##0 (!chanNum[0] && !cfg.evenSel) |=> selfCtrlSignal == $past(reluctancePath))
    else $error("even channel ignored reluctance path");
  a_no_self_zero: assert property (@(posedge clk) disable iff (!arst_n) // [RL12]
    ctrlInputSel != chanNum |=> !selfCtrlSignal)
    else $error("control signal without self selection");
  a_lambda_pull: assert property (@(posedge clk) disable iff (!arst_n) // [RL13]
    lambdaPullVvar |-> selfCtrlSignal && $past(pullSel) == PULL_LAMBDA)
    else $error("lambda pull without code or control");
  a_default_top: assert property (@(posedge clk) disable iff (!arst_n) // [RL11]
    csDefaultLoad |-> (csDefault[3] == SRD_CS_PU250_5V) == cfg.lambdaEn[3]
                      && csDefault[3] != SRD_CS_DEFAULT)
    else $error("wrong default on top lane");
endmodule

// >>> srd_config_tb.sv
module srd_config_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import srd_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, reluctancePath = 1'b0, ctrlCfgBit = 1'b0;
  logic [3:0] chanNum = 4'h0, ctrlInputSel = 4'h0;
  logic [2:0] pullSel = 3'h0;
  logic [7:0] rdAddr;
  logic [15:0] rdData;
  logic [10:0] varVoltageMv;
  logic csDefaultLoad, selfCtrlSignal, lambdaPullVvar;
  srd_wr_t wrReq;
  srd_cfg_t cfg;
  srd_cs_t [3:0] csDefault;
  int failures = 0, compares = 0;
  always #4 clk = ~clk;
  srd_host host (.clk(clk), .wrReq(wrReq), .rdAddr(rdAddr), .rdData(rdData));
  srd_config dut (.clk(clk), .arst_n(arst_n), .wrReq(wrReq), .rdAddr(rdAddr),
    .chanNum(chanNum), .ctrlInputSel(ctrlInputSel), .reluctancePath(reluctancePath),
    .ctrlCfgBit(ctrlCfgBit), .pullSel(pullSel), .rdData(rdData), .cfg(cfg),
    .varVoltageMv(varVoltageMv), .csDefaultLoad(csDefaultLoad), .csDefault(csDefault),
    .selfCtrlSignal(selfCtrlSignal), .lambdaPullVvar(lambdaPullVvar));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic resetValues();
    logic [15:0] d;
    host.readReg(ROUTE_ADDR, d);
    check(d, 16'h2000, "route reset");
    host.readReg(DEWET_ADDR, d);
    check(d, 16'h0000, "dewet reset");
    check({5'h00, varVoltageMv}, 16'h0320, "level reset");
  endtask
  task automatic routeFields();
    logic [15:0] d;
    host.writeReg(ROUTE_ADDR, 16'hFFFF);
    host.readReg(ROUTE_ADDR, d);
    check(d, 16'h3FFF, "route reserved");
    for (int c = 0; c < 16; c++) begin
      host.writeReg(ROUTE_ADDR, {8'h15, 4'(c), 4'h5});
      check({2'b00, cfg.evenSel, cfg.oddSel, cfg.filterEn, cfg.aoutSel, cfg.sentEn},
        {4'h1, 4'h5, 4'(c), 4'h5}, "route fields");
    end
  endtask
  task automatic dewetWrite();
    logic [15:0] d;
    host.writeReg(DEWET_ADDR, 16'hFFFF);
    check({15'h0000, csDefaultLoad}, 16'h0001, "load pulse");
    check({8'h00, csDefault}, {8'h00, {4{SRD_CS_PU250_5V}}}, "all pull-up");
    @(posedge clk) #1;
    check({15'h0000, csDefaultLoad}, 16'h0000, "load ends");
    host.readReg(DEWET_ADDR, d);
    check(d, 16'h1EFF, "dewet reserved");
    host.writeReg(DEWET_ADDR, 16'h0A00);
    check({12'h000, cfg.lambdaEn}, 16'h0005, "lambda bits");
    check({8'h00, csDefault}, {8'h00, SRD_CS_HIZ, SRD_CS_PU250_5V, SRD_CS_HIZ,
      SRD_CS_PU250_5V}, "mixed default");
  endtask
  task automatic levelSweep();
    for (int c = 0; c < 32; c++) begin
      host.writeReg(DEWET_ADDR, {8'h00, 3'(c % 8), 5'(c)});
      @(posedge clk) #1;
      check({5'h00, varVoltageMv}, 16'(c >= 22 ? 1900 : 800 + 50 * c), "level");
      check({13'h0000, cfg.dwtSel}, 16'(c % 8), "dewet time");
    end
  endtask
  task automatic selfControl();
    host.writeReg(DEWET_ADDR, 16'h0200);
    host.writeReg(ROUTE_ADDR, 16'h1000);
    chanNum = 4'h9;
    ctrlInputSel = 4'h9;
    ctrlCfgBit = 1'b1;
    pullSel = 3'h7;
    repeat (2) @(posedge clk) #1;
    check({15'h0000, selfCtrlSignal}, 16'h0001, "odd uses bit");
    check({15'h0000, lambdaPullVvar}, 16'h0001, "lambda pull");
    chanNum = 4'hA;
    ctrlInputSel = 4'hA;
    ctrlCfgBit = 1'b0;
    reluctancePath = 1'b1;
    repeat (2) @(posedge clk) #1;
    check({15'h0000, selfCtrlSignal}, 16'h0001, "even uses path");
    check({15'h0000, lambdaPullVvar}, 16'h0000, "lambda off");
  endtask
  initial begin
    #100000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    resetValues();
    routeFields();
    dewetWrite();
    levelSweep();
    selfControl();
    complete_run();
  end
endmodule

// >>> srd_host.sv
module srd_host (
  input  wire logic             clk,
  output srd_pkg::srd_wr_t      wrReq,
  output logic [7:0]            rdAddr,
  input  wire logic [15:0]      rdData
);
  timeunit 1ns;
  timeprecision 100ps;
  import srd_pkg::*;
  initial begin
    wrReq = '0;
    rdAddr = 8'h00;
  end
  // Holds one write request for one clock cycle, driven 1 ns after a rising edge
  task automatic writeReg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    wrReq <= '{wrEn: 1'b1, addr: a, wdata: d};
    @(posedge clk) #1;
    // Released lines flip so a stale word never looks fresh
    wrReq <= '{wrEn: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic readReg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk) #1;
    rdAddr = a;
    @(posedge clk) #1;
    d = rdData;
  endtask
endmodule

// >>> srd_pkg.sv
package srd_pkg;
  localparam logic [7:0] ROUTE_ADDR = 8'h30;
  localparam logic [7:0] DEWET_ADDR = 8'h31;
  localparam int SENT_LANES = 4;
  localparam int LAMBDA_LANES = 4;
  // Routing register field positions
  localparam int EVEN_BIT = 13;
  localparam int ODD_BIT = 12;
  localparam int FILT_LSB = 8;
  localparam int AOUT_LSB = 4;
  localparam int SENT_LSB = 0;
  // Dewetting register field positions
  localparam int LAMBDA_LSB = 9;
  localparam int DWT_LSB = 5;
  localparam int VARIABLE_VOLTAGE_SOURCE_LSB = 0;
  // Reset values
  localparam logic EVEN_RST = 1'b1;
  localparam logic ODD_RST = 1'b0;
  localparam logic [3:0] AOUT_RST = 4'h0;
  localparam logic [3:0] SENT_RST = 4'h0;
  localparam logic [3:0] LAMBDA_RST = 4'h0;
  localparam logic [2:0] DWT_RST = 3'h0;
  localparam logic [4:0] VARIABLE_VOLTAGE_SOURCE_RST = 5'h00;
  // Analog output source codes
  localparam logic [3:0] AOUT_HIZ = 4'h0;
  localparam logic [3:0] AOUT_CH_MAX = 4'hC;
  localparam logic [3:0] AOUT_BANDGAP = 4'hD;
  localparam logic [3:0] AOUT_ADCREF = 4'hE;
  localparam logic [3:0] AOUT_RELPOS = 4'hF;
  // Variable voltage: mV = base + step*code, saturating
  localparam int VARIABLE_VOLTAGE_SOURCE_BASE_MV = 800;
  localparam int VARIABLE_VOLTAGE_SOURCE_STEP_MV = 50;
  localparam logic [4:0] VARIABLE_VOLTAGE_SOURCE_SAT_CODE = 5'h16;
  localparam logic [10:0] VARIABLE_VOLTAGE_SOURCE_MAX_MV = 11'd1900;
  // Dewetting durations in ms
  localparam int DWT_MS_0 = 2;
  localparam int DWT_MS_1 = 16;
  localparam int DWT_MS_2 = 64;
  // Pull selection code for lambda mode
  localparam logic [2:0] PULL_LAMBDA = 3'h7;

  typedef enum logic [1:0] {SRD_CS_DEFAULT, SRD_CS_HIZ, SRD_CS_PU250_5V} srd_cs_t;

  typedef struct packed {
    logic       evenSel;
    logic       oddSel;
    logic [3:0] filterEn;
    logic [3:0] aoutSel;
    logic [3:0] sentEn;
    logic [3:0] lambdaEn;
    logic [2:0] dwtSel;
    logic [4:0] vvarCode;
  } srd_cfg_t;

  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [15:0] wdata;
  } srd_wr_t;
endpackage

// >>> srd_variable_voltage_source_decode.sv
module srd_variable_voltage_source_decode (
  input  wire logic [4:0]  code,
  output logic      [10:0] levelMv
);
  import srd_pkg::*;
  // Saturating level decode [RL8] [RL9]
  always_comb begin
    if (code >= VARIABLE_VOLTAGE_SOURCE_SAT_CODE) begin
      levelMv = VARIABLE_VOLTAGE_SOURCE_MAX_MV;
    end else begin
      levelMv = 11'(VARIABLE_VOLTAGE_SOURCE_BASE_MV + VARIABLE_VOLTAGE_SOURCE_STEP_MV * int'(code));
    end
  end
endmodule
